// ===== verilog/power_slot_pkg.sv
// constants, register map and duration ladders of the power slot sequencer
//
// Contract
// (R1) the current slot position reads back in bits 3:0 of the position register
// (R2) slots with no supply dwell for the empty-slot code time, 32 us to 8.192 ms
// (R3) every other slot dwells for the slot-length code time, same ladder
// (R4) each linear regulator has a 4-bit switching slot, two per byte
// (R5) each switcher has a 4-bit switching slot, two per byte as mapped
// (R6) pull-down disable acts at the slot in bits 7:4; bits 3:0 reserved
// (R7) each general output has assert slot in 3:0 and deassert slot in 7:4
// (R8) clock output and timekeeper clock enable at the clock-enable slot
// (R9) the pause function acts at the wait slot held in bits 3:0
// (R10) software keeps power-domain end between system end and final slot
// (R11) software keeps system-domain end between standby stop and power end
// (R12) standby power-down stops at the standby stop slot, kept 1 or above
// (R13) final slot ends the last domain; software keeps it at or above power end
// (R14) wait direction: 00 none, 01 up, 10 down, 11 both
// (R15) external wait aborts after 500 ms when timeout bit set, else waits forever
// (R16) wait mode 0 waits for external input, 1 waits for internal timer
// (R17) wait time code 0001 is 512 us, doubling per code up to 8.4 s
// (R18) wait time code zero adds no pause beyond the normal slot
// (R19) pointer moves one slot per slot time, up or down, acting on matches
// (R20) undefined ladder codes map to the next longer defined duration
package power_slot_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 32;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TIMEOUT_MS = 500;
  localparam int TIMEOUT_TICKS = (TIMEOUT_MS * 1000) / TICK_US;
  localparam int CNT_W = 20;
  localparam int WAIT_BASE_US = 512;
  localparam int LADDER_MID_US = 384;
  localparam int LADDER_HI_US = 512;
  localparam logic [CNT_W-1:0] WAIT_BASE_TICKS = CNT_W'(WAIT_BASE_US / TICK_US);
  localparam logic [CNT_W-1:0] LADDER_MID_TICKS = CNT_W'(LADDER_MID_US / TICK_US);
  localparam logic [CNT_W-1:0] LADDER_HI_TICKS = CNT_W'(LADDER_HI_US / TICK_US);
  localparam logic [3:0] LADDER_LIN_LAST = 4'h8;
  localparam logic [3:0] LADDER_MID_CODE = 4'h9;
  localparam logic [3:0] LADDER_HI_CODE = 4'hb;

  // ==========================================================================
  // register map
  localparam int REG_COUNT = 16;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int IDX_POS = 0;
  localparam int IDX_TIMING = 1;
  localparam int IDX_LIN_A = 2;
  localparam int IDX_LIN_B = 3;
  localparam int IDX_PD = 4;
  localparam int IDX_SW_A = 5;
  localparam int IDX_SW_B = 6;
  localparam int IDX_OUT0 = 7;
  localparam int IDX_CLKP = 12;
  localparam int IDX_DOMAIN = 13;
  localparam int IDX_STBY = 14;
  localparam int IDX_PAUSE = 15;
  localparam logic [7:0] REG_OFFS [REG_COUNT] = '{
    8'h81, 8'h82, 8'h83, 8'h84, 8'h88, 8'h89, 8'h8a, 8'h8d,
    8'h8e, 8'h8f, 8'h90, 8'h91, 8'h92, 8'h95, 8'h96, 8'h97};

  // field positions
  localparam int NIB_LO = 0;
  localparam int NIB_HI = 4;
  localparam int PAUSE_UP_BIT = 6;
  localparam int PAUSE_DOWN_BIT = 7;
  localparam int PAUSE_TIMEOUT_BIT = 5;
  localparam int PAUSE_MODE_BIT = 4;

  typedef enum logic [2:0] {S_IDLE, S_STEP, S_ACT, S_DWELL, S_PAUSE} slot_state_t;

  // ==========================================================================
  // duration ladders, in 32 us ticks
  function automatic logic [CNT_W-1:0] slot_ticks(input logic [3:0] code);
    logic [CNT_W-1:0] t;
    t = '0;
    if (code <= LADDER_LIN_LAST) begin
      t = CNT_W'(code) + CNT_W'(1);
    end else if (code == LADDER_MID_CODE) begin
      t = LADDER_MID_TICKS;
    end else if (code < LADDER_HI_CODE) begin
      t = LADDER_HI_TICKS; // [R20]
    end else begin
      t = LADDER_HI_TICKS << (code - LADDER_HI_CODE);
    end
    return t;
  endfunction : slot_ticks

  function automatic logic [CNT_W-1:0] wait_ticks(input logic [3:0] code);
    logic [CNT_W-1:0] t;
    t = '0;
    if (code != 4'h0) begin
      t = WAIT_BASE_TICKS << (code - 4'h1); // [R17]
    end
    return t;
  endfunction : wait_ticks

endpackage : power_slot_pkg

// ===== verilog/slot_switch.sv
// one sequenced output that turns on or off when the pointer hits its slots
`timescale 1ns/1ps
module slot_switch #(
  parameter int SLOT_W = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic act_in,
  input wire logic up_in,
  input wire logic [SLOT_W-1:0] slot_in,
  input wire logic [SLOT_W-1:0] on_slot_in,
  input wire logic [SLOT_W-1:0] off_slot_in,
  output logic state_out
);

  logic state_q;
  logic state_d;
  wire hit_on = act_in && (slot_in == on_slot_in);
  wire hit_off = act_in && (slot_in == off_slot_in);

  // a slot that is both on and off follows the direction of travel
  assign state_d = (hit_on && hit_off) ? up_in : hit_on ? 1'b1 : hit_off ? 1'b0 : state_q; // [R7]

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= 1'b0;
    end else begin
      state_q <= state_d; // [R4] [R5]
    end
  end

  assign state_out = state_q;

  // ==========================================================================
  // checks
  a_switch_on: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R4] [R5] [R7]
    hit_on && (up_in || !hit_off) |=> state_out)
    else $error("output not on after its on slot");

  a_switch_off: assert property (@(posedge clk_in) disable iff (!nrst_in) // [R7]
    hit_off && (!up_in || !hit_on) |=> !state_out)
    else $error("output not off after its off slot");

endmodule : slot_switch

// ===== verilog/power_slot_sequencer.sv
// slot sequencer: byte register file, slot timing, pause and sequenced outputs
`timescale 1ns/1ps
module power_slot_sequencer #(
  parameter int TICK_CYCLES = power_slot_pkg::TICK_CYCLES,
  parameter int TIMEOUT_TICKS = power_slot_pkg::TIMEOUT_TICKS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic power_up_in,
  input wire logic power_down_in,
  input wire logic standby_in,
  input wire logic external_wait_input_in,
  output logic [3:0] linear_en_out,
  output logic [3:0] switcher_en_out,
  output logic pulldown_off_function_out,
  output logic clk32k_en_out,
  output logic [4:0] general_output_out,
  output logic busy_out
);

  localparam int CW = power_slot_pkg::CNT_W;
  localparam int DIV_W = $clog2(TICK_CYCLES + 1);
  localparam int NRES = 15;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [CW-1:0] TIMEOUT_CNT = CW'(TIMEOUT_TICKS);

  // ==========================================================================
  // register file
  logic [7:0] cfg_q [power_slot_pkg::REG_COUNT];
  logic [power_slot_pkg::REG_COUNT-1:0] hit;
  logic [7:0] rd_mux;
  logic [7:0] rdata_q;
  logic [3:0] ptr_q;
  logic [3:0] ptr_d;

  genvar gi;
  generate
    for (gi = 0; gi < power_slot_pkg::REG_COUNT; gi++) begin : g_dec
      assign hit[gi] = (reg_addr_in == power_slot_pkg::REG_OFFS[gi]);
    end
  endgenerate

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < power_slot_pkg::REG_COUNT; i++) begin
        cfg_q[i] <= power_slot_pkg::REG_RESET;
      end
    end else if (reg_wr_in) begin
      for (int i = 0; i < power_slot_pkg::REG_COUNT; i++) begin
        if (hit[i]) begin
          cfg_q[i] <= reg_wdata_in;
        end
      end
    end
  end

  // position register keeps its upper nibble as storage, the pointer is live
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < power_slot_pkg::REG_COUNT; i++) begin
      if (hit[i]) begin
        rd_mux = cfg_q[i];
      end
    end
    if (hit[power_slot_pkg::IDX_POS]) begin
      rd_mux = {cfg_q[power_slot_pkg::IDX_POS][7:4], ptr_q}; // [R1]
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_q <= rd_mux;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ==========================================================================
  // field decode
  wire [7:0] timing_r = cfg_q[power_slot_pkg::IDX_TIMING];
  wire [7:0] clkp_r = cfg_q[power_slot_pkg::IDX_CLKP];
  wire [7:0] stby_r = cfg_q[power_slot_pkg::IDX_STBY];
  wire [7:0] pause_r = cfg_q[power_slot_pkg::IDX_PAUSE];
  wire [3:0] empty_slot_time = timing_r[power_slot_pkg::NIB_HI +: 4];
  wire [3:0] slot_length = timing_r[power_slot_pkg::NIB_LO +: 4];
  wire [3:0] clock_enable_slot = clkp_r[power_slot_pkg::NIB_HI +: 4];
  wire [3:0] wait_slot = clkp_r[power_slot_pkg::NIB_LO +: 4]; // [R9]
  wire [3:0] standby_stop_slot = stby_r[power_slot_pkg::NIB_HI +: 4];
  wire [3:0] last_power_domain = stby_r[power_slot_pkg::NIB_LO +: 4]; // [R13]
  wire pause_on_up = pause_r[power_slot_pkg::PAUSE_UP_BIT];
  wire pause_on_down = pause_r[power_slot_pkg::PAUSE_DOWN_BIT];
  wire pause_timeout_en = pause_r[power_slot_pkg::PAUSE_TIMEOUT_BIT];
  wire pause_timer_mode = pause_r[power_slot_pkg::PAUSE_MODE_BIT];
  wire [3:0] wait_time = pause_r[power_slot_pkg::NIB_LO +: 4];

  // per-resource on and off slots: 0-3 linear, 4-7 switcher, 8 pull-down,
  // 9 clock enable, 10-14 general outputs
  logic [3:0] on_slot [NRES];
  logic [3:0] off_slot [NRES];
  logic [NRES-1:0] res_state;

  wire [3:0] linear1_slot = cfg_q[power_slot_pkg::IDX_LIN_A][power_slot_pkg::NIB_LO +: 4]; // [R4]
  wire [3:0] linear2_slot = cfg_q[power_slot_pkg::IDX_LIN_A][power_slot_pkg::NIB_HI +: 4];
  wire [3:0] linear3_slot = cfg_q[power_slot_pkg::IDX_LIN_B][power_slot_pkg::NIB_LO +: 4];
  wire [3:0] linear4_slot = cfg_q[power_slot_pkg::IDX_LIN_B][power_slot_pkg::NIB_HI +: 4];
  wire [3:0] switcher1_slot = cfg_q[power_slot_pkg::IDX_SW_A][power_slot_pkg::NIB_LO +: 4]; // [R5]
  wire [3:0] switcher2_slot = cfg_q[power_slot_pkg::IDX_SW_A][power_slot_pkg::NIB_HI +: 4];
  wire [3:0] switcher3_slot = cfg_q[power_slot_pkg::IDX_SW_B][power_slot_pkg::NIB_HI +: 4];
  wire [3:0] switcher4_slot = cfg_q[power_slot_pkg::IDX_SW_B][power_slot_pkg::NIB_LO +: 4];
  wire [3:0] pulldown_off_slot = cfg_q[power_slot_pkg::IDX_PD][power_slot_pkg::NIB_HI +: 4]; // [R6]

  assign on_slot[0] = linear1_slot;
  assign on_slot[1] = linear2_slot;
  assign on_slot[2] = linear3_slot;
  assign on_slot[3] = linear4_slot;
  assign on_slot[4] = switcher1_slot;
  assign on_slot[5] = switcher2_slot;
  assign on_slot[6] = switcher3_slot;
  assign on_slot[7] = switcher4_slot;
  assign on_slot[8] = pulldown_off_slot;
  assign on_slot[9] = clock_enable_slot; // [R8]

  generate
    for (gi = 0; gi < 10; gi++) begin : g_same
      assign off_slot[gi] = on_slot[gi];
    end
    for (gi = 0; gi < 5; gi++) begin : g_gpo
      assign on_slot[10+gi] = cfg_q[power_slot_pkg::IDX_OUT0+gi][power_slot_pkg::NIB_LO +: 4]; // [R7]
      assign off_slot[10+gi] = cfg_q[power_slot_pkg::IDX_OUT0+gi][power_slot_pkg::NIB_HI +: 4];
    end
  endgenerate

  // a slot carries a supply when any regulator is assigned to it
  wire supply_hit = (linear1_slot == ptr_q) || (linear2_slot == ptr_q) ||
                    (linear3_slot == ptr_q) || (linear4_slot == ptr_q) ||
                    (switcher1_slot == ptr_q) || (switcher2_slot == ptr_q) ||
                    (switcher3_slot == ptr_q) || (switcher4_slot == ptr_q);

  // ==========================================================================
  // external input synchroniser and 32 us tick
  logic ext_meta_q;
  logic ext_sync_q;
  logic [DIV_W-1:0] div_q;
  logic cnt_clr;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
    end else begin
      ext_meta_q <= external_wait_input_in;
      ext_sync_q <= ext_meta_q;
    end
  end

  // divider restarts with each slot so a slot is never cut short by a partial tick
  wire tick = (div_q == DIV_LAST);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= '0;
    end else if (cnt_clr || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end

  // ==========================================================================
  // sequencer
  power_slot_pkg::slot_state_t state_q;
  power_slot_pkg::slot_state_t state_d;
  logic dir_up_q;
  logic [3:0] target_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] dwell_len_q;
  logic [CW-1:0] wait_len_q;
  logic pause_arm_q;
  logic pause_timer_q;
  logic pause_timeout_q;

  wire [3:0] down_target = standby_in ? standby_stop_slot : 4'h0; // [R12]
  wire idle = (state_q == power_slot_pkg::S_IDLE);
  wire up_start = idle && power_up_in && (ptr_q < last_power_domain); // [R13]
  wire down_start = idle && !power_up_in && power_down_in && (ptr_q > down_target);
  wire act = (state_q == power_slot_pkg::S_ACT);
  wire [CW-1:0] cnt_next = cnt_q + CW'(1);
  wire dwell_done = (state_q == power_slot_pkg::S_DWELL) && tick && (cnt_next >= dwell_len_q);
  wire timer_done = tick && (cnt_next >= wait_len_q);
  wire timed_out = pause_timeout_q && tick && (cnt_next >= TIMEOUT_CNT); // [R15]
  wire pause_done = (state_q == power_slot_pkg::S_PAUSE) &&
                    (pause_timer_q ? timer_done : (ext_sync_q || timed_out)); // [R16]
  wire pause_dir_ok = dir_up_q ? pause_on_up : pause_on_down; // [R14]
  wire pause_arm_d = (ptr_q == wait_slot) && pause_dir_ok &&
                     (!pause_timer_mode || (wait_time != 4'h0)); // [R9] [R18]
  wire [3:0] ptr_step = dir_up_q ? (ptr_q + 4'h1) : (ptr_q - 4'h1); // [R19]
  wire [CW-1:0] dwell_pick = supply_hit ? power_slot_pkg::slot_ticks(slot_length)
                                        : power_slot_pkg::slot_ticks(empty_slot_time); // [R2] [R3]

  assign cnt_clr = act || (dwell_done && pause_arm_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      power_slot_pkg::S_IDLE: begin
        if (up_start) begin
          state_d = power_slot_pkg::S_STEP;
        end else if (down_start) begin
          state_d = power_slot_pkg::S_ACT;
        end
      end
      power_slot_pkg::S_STEP: begin
        if (!dir_up_q && (ptr_step == target_q)) begin
          state_d = power_slot_pkg::S_IDLE;
        end else begin
          state_d = power_slot_pkg::S_ACT;
        end
      end
      power_slot_pkg::S_ACT: begin
        state_d = power_slot_pkg::S_DWELL;
      end
      power_slot_pkg::S_DWELL: begin
        if (dwell_done && pause_arm_q) begin
          state_d = power_slot_pkg::S_PAUSE;
        end else if (dwell_done) begin
          state_d = (dir_up_q && (ptr_q == target_q)) ? power_slot_pkg::S_IDLE : power_slot_pkg::S_STEP;
        end
      end
      power_slot_pkg::S_PAUSE: begin
        if (pause_done) begin
          state_d = (dir_up_q && (ptr_q == target_q)) ? power_slot_pkg::S_IDLE : power_slot_pkg::S_STEP;
        end
      end
      default: begin
        state_d = power_slot_pkg::S_IDLE;
      end
    endcase
  end

  assign ptr_d = (state_q == power_slot_pkg::S_STEP) ? ptr_step : ptr_q; // [R19]

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= power_slot_pkg::S_IDLE;
      ptr_q <= 4'h0;
    end else begin
      state_q <= state_d;
      ptr_q <= ptr_d;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dir_up_q <= 1'b0;
      target_q <= 4'h0;
    end else if (up_start) begin
      dir_up_q <= 1'b1;
      target_q <= last_power_domain;
    end else if (down_start) begin
      dir_up_q <= 1'b0;
      target_q <= down_target; // [R12]
    end
  end

  // slot and pause settings are frozen at the action cycle of each slot
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dwell_len_q <= '0;
      wait_len_q <= '0;
      pause_arm_q <= 1'b0;
      pause_timer_q <= 1'b0;
      pause_timeout_q <= 1'b0;
    end else if (act) begin
      dwell_len_q <= dwell_pick; // [R2] [R3]
      wait_len_q <= power_slot_pkg::wait_ticks(wait_time); // [R17]
      pause_arm_q <= pause_arm_d; // [R14]
      pause_timer_q <= pause_timer_mode; // [R16]
      pause_timeout_q <= pause_timeout_en; // [R15]
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= '0;
    end else if (cnt_clr) begin
      cnt_q <= '0;
    end else if (tick) begin
      cnt_q <= cnt_next;
    end
  end

  // ==========================================================================
  // sequenced resources
  generate
    for (gi = 0; gi < NRES; gi++) begin : g_res
      slot_switch #(
        .SLOT_W(4)
      ) u_switch (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .act_in(act),
        .up_in(dir_up_q),
        .slot_in(ptr_q),
        .on_slot_in(on_slot[gi]),
        .off_slot_in(off_slot[gi]),
        .state_out(res_state[gi])
      );
    end
  endgenerate

  assign linear_en_out = res_state[3:0];
  assign switcher_en_out = res_state[7:4];
  assign pulldown_off_function_out = res_state[8];
  assign clk32k_en_out = res_state[9];
  assign general_output_out = res_state[14:10];
  assign busy_out = !idle;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_step;
    state_q == power_slot_pkg::S_STEP && dir_up_q;
  endsequence

  sequence s_act_dwell;
    act ##1 (state_q == power_slot_pkg::S_DWELL);
  endsequence

  a_ptr_readback: assert property ( // [R1]
    reg_rd_in && hit[power_slot_pkg::IDX_POS] |=> reg_rdata_out[3:0] == $past(ptr_q))
    else $error("position register does not show the pointer");

  a_empty_dwell: assert property ( // [R2]
    act && !supply_hit |=> dwell_len_q == power_slot_pkg::slot_ticks($past(empty_slot_time)))
    else $error("empty slot dwell wrong");

  a_slot_dwell: assert property ( // [R3]
    act && supply_hit |=> dwell_len_q == power_slot_pkg::slot_ticks($past(slot_length)))
    else $error("supply slot dwell wrong");

  a_step_by_one: assert property ( // [R19]
    ptr_q != $past(ptr_q) |-> $past(state_q) == power_slot_pkg::S_STEP &&
      (ptr_q == $past(ptr_q) + 4'h1 || ptr_q == $past(ptr_q) - 4'h1))
    else $error("pointer moved other than one step");

  a_slot_cycle: assert property ( // [R19]
    s_step |=> s_act_dwell)
    else $error("up step not followed by action and dwell");

  a_pulldown_slot: assert property ( // [R6]
    act && dir_up_q && ptr_q == pulldown_off_slot |=> pulldown_off_function_out)
    else $error("pull-down disable not applied at its slot");

  a_clock_enable: assert property ( // [R8]
    act && dir_up_q && ptr_q == clock_enable_slot |=> clk32k_en_out)
    else $error("clock enable missed at its slot");

  a_pause_dir: assert property ( // [R9] [R14]
    act && (ptr_q != wait_slot || !pause_dir_ok) |=> !pause_arm_q)
    else $error("pause armed outside wait slot or direction");

  a_zero_wait: assert property ( // [R18]
    act && pause_timer_mode && wait_time == 4'h0 |=> !pause_arm_q)
    else $error("zero wait time armed a pause");

  a_wait_len: assert property ( // [R17]
    act |=> wait_len_q == power_slot_pkg::wait_ticks($past(wait_time)))
    else $error("wait timer length wrong");

  a_timer_holds: assert property ( // [R16]
    state_q == power_slot_pkg::S_PAUSE && pause_timer_q && !tick |=> state_q == power_slot_pkg::S_PAUSE)
    else $error("timer pause left without expiry");

  a_timeout_exit: assert property ( // [R15]
    state_q == power_slot_pkg::S_PAUSE && !pause_timer_q && timed_out |=> state_q != power_slot_pkg::S_PAUSE)
    else $error("external wait did not time out");

  a_ext_forever: assert property ( // [R15]
    state_q == power_slot_pkg::S_PAUSE && !pause_timer_q && !pause_timeout_q && !ext_sync_q
      |=> state_q == power_slot_pkg::S_PAUSE)
    else $error("external wait ended without input");

  a_down_stop: assert property ( // [R12]
    state_q == power_slot_pkg::S_STEP && !dir_up_q && ptr_step == target_q
      |=> idle && ptr_q == $past(target_q))
    else $error("power-down did not stop at its target");

  a_up_stop: assert property ( // [R13]
    idle && !$past(idle) && $past(dir_up_q) |-> ptr_q == target_q)
    else $error("power-up did not end at final slot");

endmodule : power_slot_sequencer

// ===== bench/wait_partner.sv
// far-side model: external source that answers the sequencer's pause
`timescale 1ns/1ps
module wait_partner (
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic [15:0] delay_in,
  output logic wait_pin_out
);
  logic [15:0] cnt_q;
  // ==========
  // pin goes active a set time into a run; zero delay never answers
  always @(negedge clk_in) begin
    if (busy_in !== 1'b1) begin
      cnt_q <= 16'h0000;
      wait_pin_out <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      wait_pin_out <= (delay_in != 16'h0000) && (cnt_q >= delay_in);
    end
  end
endmodule : wait_partner

// ===== bench/power_slot_sequencer_tb.sv
// self-checking bench for the power slot sequencer
`timescale 1ns/1ps
module power_slot_sequencer_tb;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic up_s = 1'b0;
  logic dn_s = 1'b0;
  logic stby_s = 1'b0;
  logic ext_w;
  logic pd;
  logic ck;
  logic busy;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdata;
  logic [3:0] lin;
  logic [3:0] sw;
  logic [4:0] gpo;
  logic [15:0] dly = 16'h0000;
  logic [7:0] ca [8] = '{8'h82, 8'h83, 8'h88, 8'h89, 8'h8d, 8'h8e, 8'h92, 8'h96};
  logic [7:0] cd [8] = '{8'h52, 8'h21, 8'h20, 8'h31, 8'h02, 8'h31, 8'h30, 8'h14};
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;
  // short tick and timeout keep every pause in a few hundred cycles
  power_slot_sequencer #(.TICK_CYCLES(4), .TIMEOUT_TICKS(20)) u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr), .reg_wdata_in(wd),
    .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .power_up_in(up_s),
    .power_down_in(dn_s), .standby_in(stby_s), .external_wait_input_in(ext_w),
    .linear_en_out(lin), .switcher_en_out(sw), .pulldown_off_function_out(pd),
    .clk32k_en_out(ck), .general_output_out(gpo), .busy_out(busy));
  wait_partner u_partner (.clk_in(clk_in), .busy_in(busy), .delay_in(dly), .wait_pin_out(ext_w));
  always #2 clk_in = ~clk_in;
  // ==========
  // shared tasks
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic near(input int got, input int exp, input int tol);
    chk(16'((got >= exp - tol && got <= exp + tol) ? exp : got), 16'(exp));
  endtask : near
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wd = d;
    wr_s = 1'b1;
    @(negedge clk_in);
    wr_s = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    addr = a;
    rd_s = 1'b1;
    @(negedge clk_in);
    rd_s = 1'b0;
    @(negedge clk_in);
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd
  // one sequence request; returns busy cycles, bounded
  task automatic run(input logic up, input logic stby, output int cyc);
    @(negedge clk_in);
    up_s = up;
    dn_s = !up;
    stby_s = stby;
    @(negedge clk_in);
    up_s = 1'b0;
    dn_s = 1'b0;
    cyc = 0;
    while (busy === 1'b1 && cyc < 4000) begin
      @(negedge clk_in);
      cyc++;
    end
    if (cyc >= 4000) begin
      n_mismatch++;
      end_of_test();
    end
  endtask : run
  // ==========
  // scenarios
  task automatic t_regs;
    rd(8'h81, 8'h00);
    wr(8'h81, 8'hff);
    rd(8'h81, 8'hf0);
    wr(8'h85, 8'h77);
    rd(8'h85, 8'h00);
    wr(8'h97, 8'hd0);
    rd(8'h97, 8'hd0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_up_standby;
    for (int i = 0; i < 8; i++) begin
      wr(ca[i], cd[i]);
    end
    wr(8'h95, 8'h42);
    wr(8'h97, 8'h00);
    run(1'b1, 1'b0, n);
    near(n, 68, 4);
    chk({8'h00, lin, sw}, 16'h0033);
    chk({9'h000, pd, ck, gpo}, 16'h0061);
    rd(8'h81, 8'hf4);
    run(1'b0, 1'b1, n);
    near(n, 54, 4);
    chk({8'h00, lin, sw}, 16'h0011);
    chk({14'h0000, pd, ck}, 16'h0000);
    rd(8'h81, 8'hf1);
    run(1'b0, 1'b1, n);
    chk(16'(n), 16'h0000);
    $display("test up and standby done");
  endtask : t_up_standby
  task automatic t_pause;
    dly = 16'd150;
    wr(8'h92, 8'h32);
    wr(8'h97, 8'h40);
    run(1'b1, 1'b0, n);
    chk(16'(n > 150), 16'h0001);
    dly = 16'h0000;
    wr(8'h97, 8'ha0);
    run(1'b0, 1'b0, n);
    near(n, 148, 6);
    wr(8'h97, 8'h51);
    run(1'b1, 1'b0, n);
    near(n, 132, 5);
    wr(8'h97, 8'hd0);
    run(1'b0, 1'b0, n);
    near(n, 68, 1);
    $display("test pause done");
  endtask : t_pause
  initial begin
    repeat (3) @(negedge clk_in);
    nrst_in = 1'b1;
    t_regs();
    t_up_standby();
    t_pause();
    end_of_test();
  end
endmodule : power_slot_sequencer_tb
